// [logic/sgp_pkg.sv]
/*
 * package for the six-bit general-purpose port: register indices, field widths,
 * reset values and the bus address decode constants.
 * assumes an avalon-mm slave with 32-bit data, one word per register.
 */
package sgp_pkg;
	// register indices as printed; byte address is index times four
	localparam logic [7:0] IDX_PIN_LEVEL = 8'h16;
	localparam logic [7:0] IDX_DIRECTION = 8'h17;
	localparam logic [7:0] IDX_OUT_LATCH = 8'h18;
	localparam logic [7:0] IDX_MCU_CTRL = 8'h20;
	localparam int ADDR_W = 10;
	localparam int NPIN = 6;
	localparam int TOP_PIN = 5;
	localparam int PUD_BIT = 0;
	localparam logic [5:0] DIR_RESET = 6'h00;
	localparam logic [5:0] LATCH_RESET = 6'h00;
	localparam logic MCU_CTRL_RESET = 1'b0;
	localparam logic [5:0] ANALOG_PINS = 6'h3c;
	localparam int SCK_PIN = 2;
	localparam int MISO_PIN = 1;
	localparam int MOSI_PIN = 0;
	localparam int CMP_PIN = 1;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

// [logic/sgp_port.sv]
/*
 * six-bit bidirectional general-purpose port with avalon-mm register access.
 * assumes a single 20 mhz clock, synchronous active-high reset, pins arriving
 * synchronous to the clock, and an external pad that resolves pull-up, drive
 * and enable signals into a wire level.
 */
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps

module sgp_port
(
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_clk_en,
	input wire logic [9:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic [5:0] i_pin,
	output logic [5:0] o_pin_out,
	output logic [5:0] o_pin_oe,
	output logic [5:0] o_pin_pullup,
	input wire logic i_reset_pin_disable_fuse,
	input wire logic i_sleep_deep,
	input wire logic i_prog_mode,
	input wire logic i_prog_miso,
	input wire logic i_cmp_enable,
	input wire logic i_cmp_out,
	output logic [5:0] o_pin_change_level,
	output logic o_ext_int_zero_level,
	output logic o_counter_zero_ext_clock,
	output logic o_prog_sck,
	output logic o_prog_mosi,
	output logic o_ext_reset_n
);
	// ****************************************************************
	// register state and bus decode
	// ****************************************************************
	logic [5:0] direction_control_r;
	logic [5:0] output_data_latch_r;
	logic global_pullup_disable_r;
	logic [5:0] sync1_r;
	logic [5:0] sync2_r;
	logic ack_r;
	logic [7:0] reg_index;
	logic word_ok;
	logic wr_dir;
	logic wr_lat;
	logic wr_mcu;
	logic [5:0] pin_live;
	logic [5:0] out_nxt;
	logic [5:0] oe_nxt;
	logic [5:0] pu_nxt;
	logic top_as_reset;
	logic [31:0] rdata_nxt;

	// word addressing: low two address bits must be zero
	assign reg_index = i_avs_address[9:2];
	assign word_ok = (i_avs_address[1:0] == 2'b00);
	// write takes effect on the edge where waitrequest is seen low
	assign wr_dir = i_avs_write && ack_r && word_ok && (reg_index == sgp_pkg::IDX_DIRECTION) && i_avs_byteenable[0];
	assign wr_lat = i_avs_write && ack_r && word_ok && (reg_index == sgp_pkg::IDX_OUT_LATCH) && i_avs_byteenable[0];
	assign wr_mcu = i_avs_write && ack_r && word_ok && (reg_index == sgp_pkg::IDX_MCU_CTRL) && i_avs_byteenable[0];
	assign top_as_reset = !i_reset_pin_disable_fuse;

	// one wait cycle per access: waitrequest drops the cycle after request rises
	// waitrequest kept in its own flop so the bus output has no gate after it
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			ack_r <= 1'b0;
			o_avs_waitrequest <= 1'b1;
		end
		else if (i_clk_en)
		begin
			ack_r <= (i_avs_read || i_avs_write) && !ack_r;
			o_avs_waitrequest <= !((i_avs_read || i_avs_write) && !ack_r);
		end
	end

	// direction register; each bit stored independently so bit set/clear is safe
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			direction_control_r <= sgp_pkg::DIR_RESET;
		else if (i_clk_en && wr_dir)
			direction_control_r <= i_avs_writedata[5:0];
	end

	// output data latch
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			output_data_latch_r <= sgp_pkg::LATCH_RESET;
		else if (i_clk_en && wr_lat)
			output_data_latch_r <= i_avs_writedata[5:0];
	end

	// control word holding the global pull-up disable
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			global_pullup_disable_r <= sgp_pkg::MCU_CTRL_RESET;
		else if (i_clk_en && wr_mcu)
			global_pullup_disable_r <= i_avs_writedata[sgp_pkg::PUD_BIT];
	end

	// read data, valid on the edge where waitrequest is low
	always_comb
	begin
		rdata_nxt = sgp_pkg::UNMAPPED_DATA;
		if (word_ok)
		begin
			unique case (reg_index)
				sgp_pkg::IDX_PIN_LEVEL: rdata_nxt = {26'h0, sync2_r};
				sgp_pkg::IDX_DIRECTION: rdata_nxt = {26'h0, direction_control_r};
				sgp_pkg::IDX_OUT_LATCH: rdata_nxt = {26'h0, output_data_latch_r};
				sgp_pkg::IDX_MCU_CTRL: rdata_nxt = {31'h0, global_pullup_disable_r};
				default: rdata_nxt = sgp_pkg::UNMAPPED_DATA;
			endcase
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			o_avs_readdata <= 32'h0000_0000;
		else if (i_clk_en)
			o_avs_readdata <= (i_avs_read && !ack_r) ? rdata_nxt : o_avs_readdata;
	end

	// ****************************************************************
	// input path
	// ****************************************************************

	// sleeping analog pins read low so a mid-rail voltage costs no current
	assign pin_live = i_pin & ~({6{i_sleep_deep}} & sgp_pkg::ANALOG_PINS);

	// two-stage synchronizer; first stage feeds only the second
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			sync1_r <= 6'h00;
			sync2_r <= 6'h00;
		end
		else if (i_clk_en)
		begin
			sync1_r <= pin_live;
			sync2_r <= sync1_r;
		end
	end

	// alternate-function and detector feeds, registered from synced levels
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			o_pin_change_level <= 6'h00;
			o_ext_int_zero_level <= 1'b0;
			o_counter_zero_ext_clock <= 1'b0;
			o_prog_sck <= 1'b0;
			o_prog_mosi <= 1'b0;
			o_ext_reset_n <= 1'b1;
		end
		else if (i_clk_en)
		begin
			o_pin_change_level <= sync2_r;
			// taken regardless of direction: output activity still triggers
			o_ext_int_zero_level <= !i_prog_mode && sync2_r[sgp_pkg::SCK_PIN];
			o_counter_zero_ext_clock <= sync2_r[sgp_pkg::SCK_PIN];
			o_prog_sck <= i_prog_mode && sync2_r[sgp_pkg::SCK_PIN];
			o_prog_mosi <= i_prog_mode && sync2_r[sgp_pkg::MOSI_PIN];
			o_ext_reset_n <= top_as_reset ? sync2_r[sgp_pkg::TOP_PIN] : 1'b1;
		end
	end

	// ****************************************************************
	// output path
	// ****************************************************************

	// per-pin drive, enable and pull-up for the push-pull pins
	genvar g;
	generate
		for (g = 0; g < sgp_pkg::TOP_PIN; g++)
		begin : g_pp
			always_comb
			begin
				oe_nxt[g] = direction_control_r[g];
				out_nxt[g] = output_data_latch_r[g];
				pu_nxt[g] = !direction_control_r[g] && output_data_latch_r[g] && !global_pullup_disable_r;
				if (i_prog_mode && g == sgp_pkg::MISO_PIN)
				begin
					oe_nxt[g] = 1'b1;
					out_nxt[g] = i_prog_miso;
					pu_nxt[g] = 1'b0;
				end
				else if (i_cmp_enable && g == sgp_pkg::CMP_PIN)
				begin
					// direction still set by software for the compare pin
					out_nxt[g] = i_cmp_out;
				end
			end
		end
	endgenerate

	// top pin: open-drain low only, never a pull-up; reset role ignores bits
	always_comb
	begin
		oe_nxt[sgp_pkg::TOP_PIN] = !top_as_reset && direction_control_r[sgp_pkg::TOP_PIN];
		out_nxt[sgp_pkg::TOP_PIN] = 1'b0;
		pu_nxt[sgp_pkg::TOP_PIN] = 1'b0;
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			o_pin_out <= 6'h00;
			o_pin_oe <= 6'h00;
			o_pin_pullup <= 6'h00;
		end
		else if (i_clk_en)
		begin
			o_pin_out <= out_nxt;
			o_pin_oe <= oe_nxt;
			o_pin_pullup <= pu_nxt;
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************

	chk_dir_reset_zero: assert property (@(posedge i_clock) $fell(i_rst) |-> direction_control_r == 6'h00)
		else $error("direction not zero after reset");

	chk_pullup_gate: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_clk_en && !i_prog_mode && !direction_control_r[0] && output_data_latch_r[0] && !global_pullup_disable_r)
		|=> o_pin_pullup[0])
		else $error("pull-up not enabled on input pin");

	chk_global_pud: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_clk_en && global_pullup_disable_r) |=> o_pin_pullup == 6'h00)
		else $error("pull-up active while globally disabled");

	chk_drive_level: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_clk_en && !i_prog_mode && !i_cmp_enable && direction_control_r[1])
		|=> o_pin_oe[1] && o_pin_out[1] == $past(output_data_latch_r[1]))
		else $error("output pin drive mismatch");

	chk_top_open_drain: assert property (@(posedge i_clock) disable iff (i_rst)
		o_pin_out[5] == 1'b0 && o_pin_pullup[5] == 1'b0)
		else $error("top pin drives high or pulls up");

	chk_reset_ignores: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_clk_en && top_as_reset) |=> !o_pin_oe[5])
		else $error("top pin driven while serving reset");

	chk_sync_depth: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_clk_en [*3]) |-> sync2_r == $past(pin_live, 2))
		else $error("synchronizer depth wrong");

	chk_pin_view_read: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_clk_en && i_avs_read && !ack_r && word_ok && reg_index == sgp_pkg::IDX_PIN_LEVEL)
		|=> o_avs_readdata == {26'h0, $past(sync2_r)})
		else $error("pin view read mismatch");

	chk_upper_zero: assert property (@(posedge i_clock) disable iff (i_rst)
		!o_avs_waitrequest |-> o_avs_readdata[31:6] == 26'h0 || reg_index == sgp_pkg::IDX_MCU_CTRL)
		else $error("upper bits not zero");

	// a pending request is answered after exactly one wait cycle
	chk_wait_released: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_clk_en && (i_avs_read || i_avs_write) && o_avs_waitrequest) |=> !o_avs_waitrequest)
		else $error("waitrequest not released");

	// the pin view takes no writes: direction and latch registers stay put
	chk_view_readonly: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_clk_en && i_avs_write && reg_index == sgp_pkg::IDX_PIN_LEVEL)
		|=> $stable(direction_control_r) && $stable(output_data_latch_r))
		else $error("pin view write changed a register");

	// a direction write stores exactly the six written bits
	chk_dir_write: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_clk_en && wr_dir) |=> direction_control_r == $past(i_avs_writedata[5:0]))
		else $error("direction write not stored");

	// a latch write stores exactly the six written bits
	chk_latch_write: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_clk_en && wr_lat) |=> output_data_latch_r == $past(i_avs_writedata[5:0]))
		else $error("latch write not stored");

	// a cleared direction bit leaves pin three undriven
	chk_input_undriven: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_clk_en && !direction_control_r[3]) |=> !o_pin_oe[3])
		else $error("input pin driven");

	// sleeping analog pins never reach the synchronizer
	chk_analog_mask: assert property (@(posedge i_clock) disable iff (i_rst)
		i_sleep_deep |-> (pin_live & sgp_pkg::ANALOG_PINS) == 6'h00)
		else $error("analog pin receiver not disconnected");

	// detector feed follows the synchronized levels by one register
	chk_change_feed: assert property (@(posedge i_clock) disable iff (i_rst)
		i_clk_en |=> o_pin_change_level == $past(sync2_r))
		else $error("pin change feed mismatch");

	// interrupt feed follows pin two in normal mode, whatever its direction
	chk_int_zero_feed: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_clk_en && !i_prog_mode) |=> o_ext_int_zero_level == $past(sync2_r[2]))
		else $error("interrupt zero feed mismatch");

	// counter clock feed follows pin two
	chk_counter_feed: assert property (@(posedge i_clock) disable iff (i_rst)
		i_clk_en |=> o_counter_zero_ext_clock == $past(sync2_r[2]))
		else $error("counter clock feed mismatch");

	// programming mode drives serial data out on pin one
	chk_prog_pins: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_clk_en && i_prog_mode) |=> o_pin_oe[1] && o_pin_out[1] == $past(i_prog_miso))
		else $error("programming data out mismatch");

	// compare output replaces the latch value on pin one
	chk_cmp_route: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_clk_en && !i_prog_mode && i_cmp_enable) |=> o_pin_out[1] == $past(i_cmp_out))
		else $error("compare output not routed");

	// with the fuse programmed the reset output stays released
	chk_ext_reset_idle: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_clk_en && !top_as_reset) |=> o_ext_reset_n)
		else $error("reset asserted while pin five is general purpose");

	// a low clock enable freezes registers and pin outputs
	chk_freeze_hold: assert property (@(posedge i_clock) disable iff (i_rst)
		!i_clk_en |=> $stable(direction_control_r) && $stable(o_pin_oe) && $stable(sync2_r))
		else $error("state changed while clock enable low");
endmodule

// [bench/sgp_pad_model.sv]
/*
 * board-side pad model for the six-bit port: resolves drive, enable, pull-up
 * and an external driver into the level seen on each pin.
 * assumes one clock; a pin nobody drives toggles each cycle, so no test relies on it.
 */
`timescale 1ns/1ps

module sgp_pad_model
(
	input wire logic i_clock,
	input wire logic [5:0] i_pin_out,
	input wire logic [5:0] i_pin_oe,
	input wire logic [5:0] i_pin_pullup,
	input wire logic [5:0] i_ext_en,
	input wire logic [5:0] i_ext_val,
	output logic [5:0] o_pin
);
	logic float_r = 1'b0;

	// floating level changes every cycle so a stale value never reads back
	always_ff @(posedge i_clock)
	begin
		float_r <= !float_r;
	end

	// design drive wins, then the board driver, then the pull-up
	always_comb
	begin
		for (int i = 0; i < 6; i++)
		begin
			if (i_pin_oe[i])
				o_pin[i] = i_pin_out[i];
			else if (i_ext_en[i])
				o_pin[i] = i_ext_val[i];
			else if (i_pin_pullup[i])
				o_pin[i] = 1'b1;
			else
				o_pin[i] = float_r;
		end
	end
endmodule

// [bench/six_bit_gpio_port_tb_top.sv]
/*
 * self-checking bench for the six-bit port: bus tasks, pad model, scenarios.
 * assumes the 1-wait-cycle avalon slave and the 2-stage pin synchronizer.
 */
`timescale 1ns/1ps

module six_bit_gpio_port_tb_top;
	localparam logic [9:0] A_PIN = {sgp_pkg::IDX_PIN_LEVEL, 2'b00};
	localparam logic [9:0] A_DIR = {sgp_pkg::IDX_DIRECTION, 2'b00};
	localparam logic [9:0] A_LAT = {sgp_pkg::IDX_OUT_LATCH, 2'b00};
	localparam logic [9:0] A_MCU = {sgp_pkg::IDX_MCU_CTRL, 2'b00};
	logic i_clock = 1'b0;
	logic i_rst = 1'b1;
	logic [9:0] addr = '0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = '0;
	logic fuse = 1'b1;
	logic ce = 1'b1;
	logic sleep = 1'b0;
	logic prog = 1'b0;
	logic miso = 1'b0;
	logic cmpen = 1'b0;
	logic cmpo = 1'b0;
	logic [5:0] ext_en = '0;
	logic [5:0] ext_val = '0;
	logic [5:0] pin;
	logic [31:0] o_avs_readdata;
	logic o_avs_waitrequest;
	logic [5:0] o_pin_out, o_pin_oe, o_pin_pullup, o_pin_change_level;
	logic o_ext_int_zero_level, o_counter_zero_ext_clock, o_prog_sck, o_prog_mosi, o_ext_reset_n;
	int fails = 0;
	int checked = 0;

	// ************************************************************
	// clock, design and pads
	// ************************************************************
	always #25 i_clock = !i_clock;

	sgp_port dut_u (.i_clock(i_clock), .i_rst(i_rst), .i_clk_en(ce), .i_avs_address(addr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
		.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .i_pin(pin),
		.o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_pin_pullup(o_pin_pullup),
		.i_reset_pin_disable_fuse(fuse), .i_sleep_deep(sleep), .i_prog_mode(prog), .i_prog_miso(miso),
		.i_cmp_enable(cmpen), .i_cmp_out(cmpo), .o_pin_change_level(o_pin_change_level),
		.o_ext_int_zero_level(o_ext_int_zero_level), .o_counter_zero_ext_clock(o_counter_zero_ext_clock),
		.o_prog_sck(o_prog_sck), .o_prog_mosi(o_prog_mosi), .o_ext_reset_n(o_ext_reset_n));

	sgp_pad_model pad_u (.i_clock(i_clock), .i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe),
		.i_pin_pullup(o_pin_pullup), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pin(pin));

	// ************************************************************
	// tasks
	// ************************************************************
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// request held until waitrequest is sampled low; bounded so a hang ends the run
	task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge i_clock);
		addr <= a;
		wdata <= d;
		rd <= !w;
		wr <= w;
		n = 0;
		do
		begin
			@(posedge i_clock);
			n++;
		end
		while (o_avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20)
		begin
			fails++;
			end_sim();
		end
		q = o_avs_readdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task automatic wreg(input logic [9:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rreg(input logic [9:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge i_clock);
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	initial
	begin
		repeat (2) @(posedge i_clock);
		i_rst <= 1'b0;
		rreg(A_DIR, 32'h0);
		rreg(10'h100, 32'h0);
		wreg(A_DIR, 32'hff);
		rreg(A_DIR, 32'h3f);
		wreg(A_DIR, 32'h0f);
		wreg(A_LAT, 32'h13);
		settle(2);
		chk(32'(o_pin_oe), 32'h0f);
		chk(32'(o_pin_out & o_pin_oe), 32'h03);
		chk(32'(o_pin_pullup), 32'h10);
		wreg(A_MCU, 32'h1);
		settle(2);
		chk(32'(o_pin_pullup), 32'h0);
		wreg(A_MCU, 32'h0);
		wreg(A_LAT, 32'h03);
		settle(2);
		chk(32'({o_pin_oe, o_pin_out & o_pin_oe, o_pin_pullup}), 32'h0f0c0);
		// pins 4 and 5 driven by the board, the rest by the port
		ext_en <= 6'h30;
		ext_val <= 6'h30;
		settle(4);
		rreg(A_PIN, 32'h33);
		chk(32'(o_pin_change_level), 32'h33);
		chk(32'(o_ext_int_zero_level), 32'h0);
		wreg(A_PIN, 32'h0);
		rreg(A_LAT, 32'h03);
		wreg(A_LAT, 32'h07);
		settle(5);
		chk(32'({o_ext_int_zero_level, o_counter_zero_ext_clock}), 32'h3);
		// analog pins two to five read low while asleep
		sleep <= 1'b1;
		settle(4);
		rreg(A_PIN, 32'h03);
		sleep <= 1'b0;
		ext_en <= 6'h10;
		wreg(A_DIR, 32'h2f);
		wreg(A_LAT, 32'h27);
		settle(4);
		chk(32'({o_pin_oe[5], o_pin_out[5], o_pin_pullup[5]}), 32'h4);
		rreg(A_PIN, 32'h17);
		fuse <= 1'b0;
		ext_en <= 6'h30;
		ext_val <= 6'h10;
		settle(4);
		chk(32'({o_pin_oe[5], o_ext_reset_n}), 32'h0);
		ext_val <= 6'h30;
		settle(4);
		chk(32'(o_ext_reset_n), 32'h1);
		fuse <= 1'b1;
		wreg(A_DIR, 32'h0);
		@(posedge i_clock);
		prog <= 1'b1;
		miso <= 1'b1;
		ext_en <= 6'h05;
		ext_val <= 6'h05;
		settle(4);
		chk(32'({o_prog_sck, o_prog_mosi, o_pin_oe[1], o_pin_out[1]}), 32'hf);
		prog <= 1'b0;
		wreg(A_DIR, 32'h02);
		wreg(A_LAT, 32'h0);
		@(posedge i_clock);
		cmpen <= 1'b1;
		cmpo <= 1'b1;
		settle(2);
		chk(32'({o_pin_oe[1], o_pin_out[1]}), 32'h3);
		cmpo <= 1'b0;
		settle(2);
		chk(32'(o_pin_out[1]), 32'h0);
		// clock enable low: pin zero change must not reach the detector feed
		ce <= 1'b0;
		ext_val <= 6'h04;
		settle(4);
		chk(32'(o_pin_change_level[0]), 32'h1);
		ce <= 1'b1;
		settle(4);
		chk(32'(o_pin_change_level[0]), 32'h0);
		end_sim();
	end
endmodule
